// ===== trap_and_interrupt_entry.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tie_regs.svh"
module trap_and_interrupt_entry (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core state
  input wire logic [23:0] pcIn,
  input wire logic [7:0] pageBaseByte,
  input wire logic [15:0] intPage,
  input wire logic [23:0] longStackPointer,
  input wire logic [15:0] shortStackPointer,
  input wire logic longAddrModeBit,
  input wire logic mixedMemoryEnable,
  // requests
  input wire logic intReq,
  input wire logic [8:0] vectorBus,
  input wire logic fetchValid,
  input wire logic [7:0] fetchOpcode,
  input wire logic rstReq,
  input wire logic [2:0] rstIdx,
  // illegal table fill
  input wire logic illWrEn,
  input wire logic [2:0] illWrIdx,
  input wire logic [7:0] illWrCode,
  // memory
  output logic memWr,
  output logic memRd,
  output logic [23:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  // results
  output logic busy,
  output logic done,
  output logic [23:0] pcOut,
  output logic [23:0] longStackOut,
  output logic [15:0] shortStackOut,
  output logic longAddrModeOut,
  output logic intEnableFlagAClr,
  output logic intEnableFlagBClr,
  output logic suffixActive,
  output logic suffixLongData,
  output logic suffixLongInstr
);
  tie_mem_if lk ();
  tie_pkg::tie_state_e st_r, st_nxt;
  logic [23:0] pc_r, pc_nxt, lsp_r, lsp_nxt;
  logic [15:0] ssp_r, ssp_nxt;
  logic busy_r, busy_nxt;
  logic [31:0] bytes_r, bytes_nxt;
  logic [3:0] useLong_r, useLong_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] vcnt_r, vcnt_nxt;
  logic isInt_r, isInt_nxt, pendTrap_r, pendTrap_nxt;
  logic mode_r, mode_nxt, wr_r, wr_nxt, rd_r, rd_nxt, done_r, done_nxt, clr_r, clr_nxt;
  logic [23:0] addr_r, addr_nxt, vaddr_r, vaddr_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic sfx_r, sfx_nxt, sfxD_r, sfxD_nxt, sfxI_r, sfxI_nxt;
  logic isSfx;

  assign lk.opcode = fetchOpcode;
  tie_illegal_table #(.N(`TIE_ILLEGAL_COUNT)) u_tab (
    .clk(clk),
    .rst(rst),
    .lk(lk.dec),
    .wrEn(illWrEn),
    .wrIdx(illWrIdx),
    .wrCode(illWrCode)
  );

  assign isSfx = (fetchOpcode == `TIE_SFX_SHORT_SHORT) || (fetchOpcode == `TIE_SFX_LONG_SHORT) ||
                 (fetchOpcode == `TIE_SFX_SHORT_LONG) || (fetchOpcode == `TIE_SFX_LONG_LONG);

  // ------------------------------------------------
  // sequencer
  // ------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    lsp_nxt = lsp_r;
    ssp_nxt = ssp_r;
    bytes_nxt = bytes_r;
    useLong_nxt = useLong_r;
    cnt_nxt = cnt_r;
    vcnt_nxt = vcnt_r;
    isInt_nxt = isInt_r;
    pendTrap_nxt = 1'b0;
    mode_nxt = mode_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    done_nxt = 1'b0;
    clr_nxt = 1'b0;
    addr_nxt = addr_r;
    vaddr_nxt = vaddr_r;
    wd_nxt = wd_r;
    sfx_nxt = sfx_r;
    sfxD_nxt = sfxD_r;
    sfxI_nxt = sfxI_r;
    case (st_r)
      tie_pkg::TIE_IDLE: begin
        mode_nxt = longAddrModeBit;
        lsp_nxt = longStackPointer;
        ssp_nxt = shortStackPointer;
        pendTrap_nxt = fetchValid && !isSfx;
        if (fetchValid && isSfx) begin
          sfx_nxt = 1'b1;
          sfxD_nxt = fetchOpcode[0];
          sfxI_nxt = fetchOpcode[1];
        end else if (fetchValid) begin
          sfx_nxt = 1'b0;
        end
        if (intReq) begin
          isInt_nxt = 1'b1;
          clr_nxt = 1'b1;
          vaddr_nxt = (mixedMemoryEnable || longAddrModeBit) ? {intPage[15:1], vectorBus} :
                      {pageBaseByte, intPage[7:1], vectorBus};
          // return bytes pushed before marker, high byte first
          if (longAddrModeBit) begin
            bytes_nxt = {pcIn[23:16], pcIn[15:8], pcIn[7:0], `TIE_MARK_INT_LONG};
            useLong_nxt = 4'hf;
            cnt_nxt = mixedMemoryEnable ? 3'h4 : 3'h3;
          end else if (mixedMemoryEnable) begin
            bytes_nxt = {pcIn[15:8], pcIn[7:0], `TIE_MARK_INT_SHORT, 8'h00};
            useLong_nxt = 4'hf;
            cnt_nxt = 3'h3;
          end else begin
            bytes_nxt = {pcIn[15:8], pcIn[7:0], 16'h0000};
            useLong_nxt = 4'h0;
            cnt_nxt = 3'h2;
          end
          st_nxt = tie_pkg::TIE_PUSH;
        end else if (pendTrap_r && lk.illegal) begin
          isInt_nxt = 1'b0;
          if (longAddrModeBit) begin
            bytes_nxt = {pcIn[23:16], pcIn[15:8], pcIn[7:0], `TIE_MARK_TRAP_LONG};
            useLong_nxt = 4'hf;
            cnt_nxt = mixedMemoryEnable ? 3'h4 : 3'h3;
          end else begin
            bytes_nxt = {pcIn[15:8], pcIn[7:0], `TIE_MARK_TRAP_SHORT, 8'h00};
            useLong_nxt = 4'h2;
            cnt_nxt = mixedMemoryEnable ? 3'h3 : 3'h2;
          end
          st_nxt = tie_pkg::TIE_PUSH;
        end else if (rstReq) begin
          if (longAddrModeBit) begin
            pc_nxt = {18'h00000, rstIdx, 3'h0};
          end else begin
            pc_nxt = {pageBaseByte, 10'h000, rstIdx, 3'h0};
          end
          done_nxt = 1'b1;
          st_nxt = tie_pkg::TIE_DONE;
        end
      end
      tie_pkg::TIE_PUSH: begin
        wr_nxt = 1'b1;
        wd_nxt = bytes_r[31:24];
        bytes_nxt = {bytes_r[23:0], 8'h00};
        useLong_nxt = {useLong_r[2:0], 1'b0};
        if (useLong_r[3]) begin
          lsp_nxt = lsp_r - 24'h000001;
          addr_nxt = lsp_r - 24'h000001;
        end else begin
          ssp_nxt = ssp_r - 16'h0001;
          addr_nxt = {pageBaseByte, ssp_r - 16'h0001};
        end
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h1) begin
          if (isInt_r) begin
            vcnt_nxt = 3'h0;
            st_nxt = tie_pkg::TIE_VREAD;
          end else begin
            pc_nxt = mode_r ? `TIE_TRAP_TARGET : {pageBaseByte, 16'h0000};
            done_nxt = 1'b1;
            st_nxt = tie_pkg::TIE_DONE;
          end
        end
      end
      tie_pkg::TIE_VREAD: begin
        rd_nxt = 1'b1;
        addr_nxt = vaddr_r + {21'h000000, vcnt_r};
        st_nxt = tie_pkg::TIE_VWAIT;
      end
      tie_pkg::TIE_VWAIT: begin
        // vector bytes land low first
        if (rd_r) begin
        end else begin
          case (vcnt_r)
            3'h0: pc_nxt = {pc_r[23:8], memRdata};
            3'h1: pc_nxt = {pc_r[23:16], memRdata, pc_r[7:0]};
            default: pc_nxt = {memRdata, pc_r[15:0]};
          endcase
          vcnt_nxt = vcnt_r + 3'h1;
          if (vcnt_r == ((mixedMemoryEnable || mode_r) ? 3'h2 : 3'h1)) begin
            if (!(mixedMemoryEnable || mode_r)) begin
              pc_nxt = {pageBaseByte, memRdata, pc_r[7:0]};
            end
            if (mixedMemoryEnable) begin
              mode_nxt = 1'b1;
            end
            done_nxt = 1'b1;
            st_nxt = tie_pkg::TIE_DONE;
          end else begin
            st_nxt = tie_pkg::TIE_VREAD;
          end
        end
      end
      default: begin
        st_nxt = tie_pkg::TIE_IDLE;
      end
    endcase
    busy_nxt = (st_nxt != tie_pkg::TIE_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= tie_pkg::TIE_IDLE;
      pc_r <= 24'h000000;
      lsp_r <= 24'h000000;
      ssp_r <= 16'h0000;
      busy_r <= 1'b0;
      bytes_r <= 32'h00000000;
      useLong_r <= 4'h0;
      cnt_r <= 3'h0;
      vcnt_r <= 3'h0;
      isInt_r <= 1'b0;
      pendTrap_r <= 1'b0;
      mode_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      clr_r <= 1'b0;
      addr_r <= 24'h000000;
      vaddr_r <= 24'h000000;
      wd_r <= 8'h00;
      sfx_r <= 1'b0;
      sfxD_r <= 1'b0;
      sfxI_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      lsp_r <= lsp_nxt;
      ssp_r <= ssp_nxt;
      busy_r <= busy_nxt;
      bytes_r <= bytes_nxt;
      useLong_r <= useLong_nxt;
      cnt_r <= cnt_nxt;
      vcnt_r <= vcnt_nxt;
      isInt_r <= isInt_nxt;
      pendTrap_r <= pendTrap_nxt;
      mode_r <= mode_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
      clr_r <= clr_nxt;
      addr_r <= addr_nxt;
      vaddr_r <= vaddr_nxt;
      wd_r <= wd_nxt;
      sfx_r <= sfx_nxt;
      sfxD_r <= sfxD_nxt;
      sfxI_r <= sfxI_nxt;
    end
  end

  assign memWr = wr_r;
  assign memRd = rd_r;
  assign memAddr = addr_r;
  assign memWdata = wd_r;
  assign busy = busy_r;
  assign done = done_r;
  assign pcOut = pc_r;
  assign longStackOut = lsp_r;
  assign shortStackOut = ssp_r;
  assign longAddrModeOut = mode_r;
  assign intEnableFlagAClr = clr_r;
  assign intEnableFlagBClr = clr_r;
  assign suffixActive = sfx_r;
  assign suffixLongData = sfxD_r;
  assign suffixLongInstr = sfxI_r;
endmodule
`default_nettype wire

// ===== tie_regs.svh
// Behaviour
// - vectored interrupt takes vector from 9-bit bus and clears both enable flags.
// - short mode with mixed memory pushes 16-bit return then marker 00h on long stack.
// - short mode with mixed memory sets long mode bit; PC becomes 24 bits.
// - mixed memory vector address is page bits 15..1 with vector; fetched into PC.
// - long mode with mixed memory pushes 24-bit return then marker 01h; mode stays long.
// - opcode without a defined operation causes a trap instead of execution.
// - long mode trap pushes 24-bit PC, marker 03h if mixed; PC becomes 000000h.
// - short trap: 16-bit PC onto short stack, 02h onto long if mixed; PC low 0000h.
// - a memory-mode suffix prefix never raises a trap.
// - suffix prefix runs next instruction in selected mode with that operand byte count.
// - short mode restart sets PC low to 0000h..0038h by 8, base byte kept.
// - long mode restart sets 24-bit PC to 000000h..000038h by 8.
// - short mode without mixed pushes 16-bit return on short stack; vector uses base, page 7..1.
// - long mode without mixed pushes 24-bit return on long stack, no marker; mode stays long.
`ifndef TIE_REGS_SVH
`define TIE_REGS_SVH
`define TIE_MARK_INT_SHORT 8'h00
`define TIE_MARK_INT_LONG 8'h01
`define TIE_MARK_TRAP_SHORT 8'h02
`define TIE_MARK_TRAP_LONG 8'h03
`define TIE_TRAP_TARGET 24'h000000
`define TIE_RST_STEP_LSB 3
`define TIE_SFX_SHORT_SHORT 8'h40
`define TIE_SFX_LONG_SHORT 8'h49
`define TIE_SFX_SHORT_LONG 8'h52
`define TIE_SFX_LONG_LONG 8'h5b
`define TIE_ILLEGAL_COUNT 8
`endif

// ===== tie_pkg.sv
package tie_pkg;
  typedef enum logic [2:0] {
    TIE_IDLE,
    TIE_PUSH,
    TIE_VREAD,
    TIE_VWAIT,
    TIE_DONE
  } tie_state_e;
  typedef logic [23:0] tie_addr_t;
endpackage

// ===== tie_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tie_mem_if;
  logic [7:0] opcode;
  logic illegal;
  modport dec (input opcode, output illegal);
  modport user (output opcode, input illegal);
endinterface
`default_nettype wire

// ===== tie_illegal_table.sv
`timescale 1ns/1ps
`default_nettype none
`include "tie_regs.svh"
module tie_illegal_table #(
  parameter int N = `TIE_ILLEGAL_COUNT
) (
  // clock
  input wire logic clk,
  input wire logic rst,
  // lookup
  tie_mem_if.dec lk,
  // table fill
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [7:0] wrCode
);
  logic [7:0] codes_r [N];
  logic illegal_r;
  logic hit;
  assign lk.illegal = illegal_r;
  always_ff @(posedge clk) begin
    if (wrEn) begin
      codes_r[wrIdx] <= wrCode;
    end
  end
  // suffix opcodes never count as illegal
  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (codes_r[i] == lk.opcode) begin
        hit = 1'b1;
      end
    end
    if (lk.opcode == `TIE_SFX_SHORT_SHORT || lk.opcode == `TIE_SFX_LONG_SHORT ||
        lk.opcode == `TIE_SFX_SHORT_LONG || lk.opcode == `TIE_SFX_LONG_LONG) begin
      hit = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= hit;
    end
  end
endmodule
`default_nettype wire

// ===== tie_trap_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tie_regs.svh"
module tie_trap_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests and core state
  input wire logic intReq,
  input wire logic fetchValid,
  input wire logic [7:0] fetchOpcode,
  input wire logic rstReq,
  input wire logic [2:0] rstIdx,
  input wire logic [7:0] pageBaseByte,
  input wire logic [15:0] intPage,
  input wire logic longAddrModeBit,
  input wire logic mixedMemoryEnable,
  // results
  input wire logic busy,
  input wire logic done,
  input wire logic memRd,
  input wire logic [23:0] memAddr,
  input wire logic [23:0] pcOut,
  input wire logic longAddrModeOut,
  input wire logic intEnableFlagAClr,
  input wire logic intEnableFlagBClr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // request sequences
  // ----------------------------------------
  sequence s_intTake;
    !busy && intReq;
  endsequence
  sequence s_rstTake;
    !busy && rstReq && !intReq && !$past(fetchValid);
  endsequence
  sequence s_sfxFetch;
    !busy && fetchValid && !intReq && !rstReq &&
      (fetchOpcode inside {`TIE_SFX_SHORT_SHORT, `TIE_SFX_LONG_SHORT, `TIE_SFX_SHORT_LONG, `TIE_SFX_LONG_LONG});
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_clrPair;
    intEnableFlagAClr == intEnableFlagBClr;
  endproperty
  property p_clrOnTake;
    s_intTake |=> intEnableFlagAClr && busy;
  endproperty
  property p_intLong;
    s_intTake ##0 (mixedMemoryEnable || longAddrModeBit) |-> ##[4:40] (done && longAddrModeOut);
  endproperty
  property p_intShort;
    s_intTake ##0 !(mixedMemoryEnable || longAddrModeBit) |-> ##[3:40] (done && !longAddrModeOut);
  endproperty
  property p_vecLong;
    memRd && (mixedMemoryEnable || longAddrModeBit) |-> memAddr[23:9] == intPage[15:1];
  endproperty
  property p_vecShort;
    memRd && !(mixedMemoryEnable || longAddrModeBit) |-> memAddr[23:9] == {pageBaseByte, intPage[7:1]};
  endproperty
  property p_rstLong;
    s_rstTake ##0 longAddrModeBit |=> done && pcOut == {18'h0, $past(rstIdx), 3'h0};
  endproperty
  property p_rstShort;
    s_rstTake ##0 !longAddrModeBit |=> done && pcOut == {$past(pageBaseByte), 10'h0, $past(rstIdx), 3'h0};
  endproperty
  property p_sfxNoTrap;
    s_sfxFetch ##1 (!intReq && !rstReq) |=> !busy;
  endproperty
  a_clrPair: assert property (p_clrPair) else $error("enable flag clears differ");
  a_clrOnTake: assert property (p_clrOnTake) else $error("no flag clear on interrupt");
  a_intLong: assert property (p_intLong) else $error("long mode not set after interrupt");
  a_intShort: assert property (p_intShort) else $error("short interrupt changed mode");
  a_vecLong: assert property (p_vecLong) else $error("bad long vector address");
  a_vecShort: assert property (p_vecShort) else $error("bad short vector address");
  a_rstLong: assert property (p_rstLong) else $error("bad long restart target");
  a_rstShort: assert property (p_rstShort) else $error("bad short restart target");
  a_sfxNoTrap: assert property (p_sfxNoTrap) else $error("suffix prefix trapped");
endmodule
bind trap_and_interrupt_entry tie_trap_asserts u_tie_trap_asserts (.clk, .rst, .intReq, .fetchValid,
  .fetchOpcode, .rstReq, .rstIdx, .pageBaseByte, .intPage, .longAddrModeBit, .mixedMemoryEnable,
  .busy, .done, .memRd, .memAddr, .pcOut, .longAddrModeOut, .intEnableFlagAClr, .intEnableFlagBClr);
`default_nettype wire

// ===== tie_vec_periph.sv
`timescale 1ns/1ps
`default_nettype none
module tie_vec_periph (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request side
  input wire logic fire,
  input wire logic [8:0] vecIn,
  input wire logic ackClr,
  output logic intReq,
  output logic [8:0] vectorBus,
  // vector table memory
  input wire logic memRd,
  input wire logic [23:0] memAddr,
  output logic [7:0] memRdata
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intReq <= 1'b0;
      vectorBus <= 9'h0;
      memRdata <= 8'h00;
    end else begin
      if (fire) begin
        intReq <= 1'b1;
        vectorBus <= vecIn;
      end else if (ackClr) begin
        intReq <= 1'b0;
        vectorBus <= ~vectorBus;
      end
      // table byte from address, garbage when not read
      memRdata <= memRd ? (memAddr[7:0] ^ 8'h5a) : ~memRdata;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst, longAddrModeBit, mixedMemoryEnable, intReq, fetchValid, rstReq, illWrEn, fire;
  logic [23:0] pcIn, longStackPointer, memAddr, pcOut, lspOut;
  logic [7:0] pageBaseByte, fetchOpcode, illWrCode, memWdata, memRdata;
  logic [15:0] intPage, shortStackPointer, sspOut;
  logic [8:0] vectorBus, vecIn;
  logic [2:0] rstIdx, illWrIdx;
  logic memWr, memRd, busy, done, longAddrModeOut, clrA, suffixActive, suffixLongData, suffixLongInstr;
  int n_mismatch, n_compared;
  logic [31:0] expQ[$], gotQ[$];
  trap_and_interrupt_entry u_trap_and_interrupt_entry (.clk, .rst, .pcIn, .pageBaseByte, .intPage,
    .longStackPointer, .shortStackPointer, .longAddrModeBit, .mixedMemoryEnable, .intReq, .vectorBus,
    .fetchValid, .fetchOpcode, .rstReq, .rstIdx, .illWrEn, .illWrIdx, .illWrCode, .memWr, .memRd,
    .memAddr, .memWdata, .memRdata, .busy, .done, .pcOut, .longStackOut(lspOut), .shortStackOut(sspOut),
    .longAddrModeOut, .intEnableFlagAClr(clrA), .intEnableFlagBClr(), .suffixActive, .suffixLongData,
    .suffixLongInstr);
  tie_vec_periph u_tie_vec_periph (.clk, .rst, .fire, .vecIn, .ackClr(clrA), .intReq, .vectorBus,
    .memRd, .memAddr, .memRdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (memWr === 1'b1) gotQ.push_back({memAddr, memWdata});
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic waitDone;
    int k;
    k = 0;
    #1;
    while (done !== 1'b1 && k < 80) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 80) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic pushExp(input logic [23:0] a, input logic [7:0] d);
    expQ.push_back({a, d});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic fillTable;
    for (int i = 0; i < 8; i++) begin
      illWrEn <= 1'b1;
      illWrIdx <= i[2:0];
      illWrCode <= (i == 0) ? 8'h40 : {5'h1b, i[2:0]};
      @(posedge clk);
    end
    illWrEn <= 1'b0;
    @(posedge clk);
  endtask
  task automatic entry(input bit trap, input bit lng, input bit mix);
    logic [23:0] a, sp, pc;
    logic [7:0] b;
    int nl, ns;
    a = (lng | mix) ? {intPage[15:1], vecIn} : {pageBaseByte, intPage[7:1], vecIn};
    nl = lng ? (mix ? 4 : 3) : ((!trap && mix) ? 3 : (mix ? 1 : 0));
    ns = (lng || (!trap && mix)) ? 0 : 2;
    sp = longStackPointer;
    pc = pcIn;
    b = pageBaseByte;
    if (lng) begin
      pushExp(sp - 24'h1, pc[23:16]);
      pushExp(sp - 24'h2, pc[15:8]);
      pushExp(sp - 24'h3, pc[7:0]);
      if (mix) pushExp(sp - 24'h4, trap ? 8'h03 : 8'h01);
    end else if (!trap && mix) begin
      pushExp(sp - 24'h1, pc[15:8]);
      pushExp(sp - 24'h2, pc[7:0]);
      pushExp(sp - 24'h3, 8'h00);
    end else begin
      pushExp({b, shortStackPointer - 16'h1}, pc[15:8]);
      pushExp({b, shortStackPointer - 16'h2}, pc[7:0]);
      if (mix) pushExp(sp - 24'h1, 8'h02);
    end
    longAddrModeBit <= lng;
    mixedMemoryEnable <= mix;
    @(posedge clk);
    if (trap) begin
      fetchValid <= 1'b1;
      fetchOpcode <= 8'hdd;
    end else fire <= 1'b1;
    @(posedge clk);
    fetchValid <= 1'b0;
    fire <= 1'b0;
    waitDone();
    if (trap) check("trapPc", pcOut, lng ? 24'h0 : {b, 16'h0});
    else if (lng | mix) check("intPc", pcOut, {a[7:0] + 8'h2, a[7:0] + 8'h1, a[7:0]} ^ 24'h5a5a5a);
    else check("intPc", pcOut, {b, {a[7:0] + 8'h1, a[7:0]} ^ 16'h5a5a});
    check("mode", longAddrModeOut, trap ? lng : (lng | mix));
    check("lsp", lspOut, sp - nl[23:0]);
    check("ssp", sspOut, shortStackPointer - ns[15:0]);
    repeat (2) @(posedge clk);
    check("pushCount", gotQ.size(), expQ.size());
    foreach (expQ[i]) if (i < gotQ.size()) check("push", gotQ[i], expQ[i]);
    gotQ.delete();
    expQ.delete();
  endtask
  task automatic restarts;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        longAddrModeBit <= m[0];
        rstReq <= 1'b1;
        rstIdx <= i[2:0];
        @(posedge clk);
        rstReq <= 1'b0;
        waitDone();
        check("rstPc", pcOut, m ? {18'h0, i[2:0], 3'h0} : {pageBaseByte, 10'h0, i[2:0], 3'h0});
        @(posedge clk);
      end
    end
  endtask
  task automatic suffixes;
    logic [7:0] op[4] = '{8'h40, 8'h49, 8'h52, 8'h5b};
    logic [1:0] md[4] = '{2'b00, 2'b10, 2'b01, 2'b11};
    for (int i = 0; i < 4; i++) begin
      fetchValid <= 1'b1;
      fetchOpcode <= op[i];
      @(posedge clk);
      fetchValid <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("sfxBusy", busy, 1'b0);
      check("sfxMode", {suffixActive, suffixLongData, suffixLongInstr}, {1'b1, md[i]});
      @(posedge clk);
    end
  endtask
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst = 1'b1;
    {longAddrModeBit, mixedMemoryEnable, fetchValid, rstReq, illWrEn, fire} = 6'h0;
    pcIn = 24'h3c5a96;
    longStackPointer = 24'h001000;
    shortStackPointer = 16'h2000;
    pageBaseByte = 8'h7e;
    intPage = 16'hab00;
    vecIn = 9'h104;
    {fetchOpcode, illWrCode, rstIdx, illWrIdx} = 22'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    fillTable();
    for (int t = 0; t < 2; t++) for (int m = 0; m < 4; m++) entry(t[0], m[1], m[0]);
    restarts();
    suffixes();
    results();
  end
endmodule
`default_nettype wire
